//--- logic/sat_map.svh
// Address, code and reset constants for the storage adapter address table
`ifndef SAT_MAP_SVH
`define SAT_MAP_SVH
`define SAT_MAINT_BASE 18'h3F910
`define SAT_MAINT_STEP 18'h00004
`define SAT_CSR_MIN 18'h3E008
`define SAT_CSR_MAX 18'h3FFFC
`define SAT_CSR_SPAN 18'h00002
`define SAT_MODEL_DISK 8'h15
`define SAT_MODEL_TAPE 8'h16
`define SAT_BLANK_ADP_NODE 3'h7
`endif

//--- logic/sat_pkg.sv
// Types shared by the storage adapter address table
package sat_pkg;
  typedef enum logic [2:0] {
    SAT_OP_SHOW,
    SAT_OP_SET_ADP,
    SAT_OP_SET_DEV,
    SAT_OP_CLEAR,
    SAT_OP_EXIT,
    SAT_OP_QUIT
  } sat_op_t;

  typedef struct packed {
    logic en;
    logic [17:0] control_status_address;
    logic [7:0] model;
  } sat_entry_t;

  typedef struct packed {
    sat_op_t op;
    logic [2:0] node;
    logic [17:0] control_status_address;
    logic [7:0] model;
  } sat_cmd_t;

  typedef struct packed {
    logic [2:0] node;
    logic is_adp;
    sat_entry_t entry;
  } sat_show_t;
endpackage

//--- logic/sat_table.sv
// Storage adapter address table: maintenance editing and address decode
// Overview of operation
// - One emulated controller per storage element, each at its own address.
// - Controller addresses come from the nonvolatile table, never switches.
// - Stored address is the lowest address of the controller's block.
// - Table reachable only while switches select maintenance mode.
// - Switches pick controller number 0..3; adapter answers at matching address.
// - Maintenance addresses 774420, 774424, 774430, 774434 octal.
// - Entry holds node, address, model; entries read back for display.
// - Blank table holds only adapter entry at node 7.
// - Host may move the adapter marker to a chosen node.
// - Setting node with address and model enables its entry.
// - Clearing a node disables its entry; nothing answers for it.
// - Commit writes nonvolatile table; abandon leaves it unchanged.
// - Model code 21 means disk, 22 means tape.
// - Switch 1 off leaves maintenance; table addresses then answered.
`include "sat_map.svh"
module sat_table #(
  parameter int NODES = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_maint_sw,
  input wire logic [1:0] i_ctrl_sel_sw,
  input wire logic i_nv_erase,
  input wire logic i_cmd_valid,
  input wire logic [17:0] i_cmd_addr,
  input wire sat_pkg::sat_cmd_t i_cmd,
  input wire logic i_bus_valid,
  input wire logic [17:0] i_bus_addr,
  output logic o_cmd_ack,
  output logic o_cmd_err,
  output sat_pkg::sat_show_t o_show,
  output logic o_bus_hit,
  output logic [2:0] o_bus_node,
  output logic o_bus_reg,
  output logic o_in_maint,
  output logic [2:0] o_adp_node
);
  // Node numbers are three bits wide on the interconnect
  if (NODES != 8) begin : g_bad_nodes
    $error("sat_table: NODES must be 8");
  end

  // Switch synchronisers; only stage two feeds logic
  logic [1:0] maint_sync_r;
  logic [1:0] maint_sync_nxt;
  logic [1:0] sel_s1_r;
  logic [1:0] sel_s1_nxt;
  logic [1:0] sel_s2_r;
  logic [1:0] sel_s2_nxt;
  logic maint_d_r;
  logic maint_d_nxt;
  logic maint;

  always_comb begin
    maint_sync_nxt = {maint_sync_r[0], i_maint_sw};
    sel_s1_nxt = i_ctrl_sel_sw;
    sel_s2_nxt = sel_s1_r;
    maint_d_nxt = maint_sync_r[1];
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      maint_sync_r <= 2'h0;
      sel_s1_r <= 2'h0;
      sel_s2_r <= 2'h0;
      maint_d_r <= 1'b0;
    end else begin
      maint_sync_r <= maint_sync_nxt;
      sel_s1_r <= sel_s1_nxt;
      sel_s2_r <= sel_s2_nxt;
      maint_d_r <= maint_d_nxt;
    end
  end

  assign maint = maint_sync_r[1];

  // Nonvolatile copy and the session's working copy; vectors not kept
  sat_pkg::sat_entry_t nv_r [NODES];
  sat_pkg::sat_entry_t nv_nxt [NODES];
  logic [2:0] nv_adp_r;
  logic [2:0] nv_adp_nxt;
  sat_pkg::sat_entry_t ed_r [NODES];
  sat_pkg::sat_entry_t ed_nxt [NODES];
  logic [2:0] ed_adp_r;
  logic [2:0] ed_adp_nxt;
  logic ack_r;
  logic ack_nxt;
  logic err_r;
  logic err_nxt;
  sat_pkg::sat_show_t show_r;
  sat_pkg::sat_show_t show_nxt;
  logic cmd_take;
  logic [17:0] maint_addr;
  logic args_ok;

  // Dedicated address chosen by the switch-selected controller number
  assign maint_addr = `SAT_MAINT_BASE
                    + (18'(sel_s2_r) * `SAT_MAINT_STEP);
  assign cmd_take = i_cmd_valid && maint
                  && (i_cmd_addr == maint_addr);
  assign args_ok = (i_cmd.control_status_address >= `SAT_CSR_MIN)
                 && (i_cmd.control_status_address <= `SAT_CSR_MAX)
                 && (i_cmd.control_status_address[0] == 1'b0)
                 && ((i_cmd.model == `SAT_MODEL_DISK)
                  || (i_cmd.model == `SAT_MODEL_TAPE));

  // Table editing; nonvolatile state is deliberately kept over reset
  always_comb begin
    nv_nxt = nv_r;
    nv_adp_nxt = nv_adp_r;
    ed_nxt = ed_r;
    ed_adp_nxt = ed_adp_r;
    ack_nxt = 1'b0;
    err_nxt = 1'b0;
    show_nxt = show_r;
    if (i_nv_erase) begin
      for (int i = 0; i < NODES; i++) begin
        nv_nxt[i] = '0;
        ed_nxt[i] = '0;
      end
      nv_adp_nxt = `SAT_BLANK_ADP_NODE;
      ed_adp_nxt = `SAT_BLANK_ADP_NODE;
    end else if (maint && !maint_d_r) begin
      ed_nxt = nv_r; // Fresh session starts from stored table
      ed_adp_nxt = nv_adp_r;
    end else if (cmd_take) begin
      ack_nxt = 1'b1;
      case (i_cmd.op)
        sat_pkg::SAT_OP_SHOW: begin
          show_nxt.node = i_cmd.node;
          show_nxt.is_adp = (i_cmd.node == ed_adp_r);
          show_nxt.entry = ed_r[i_cmd.node];
        end
        sat_pkg::SAT_OP_SET_ADP: begin
          ed_adp_nxt = i_cmd.node;
          ed_nxt[i_cmd.node] = '0; // Adapter owns the node now
        end
        sat_pkg::SAT_OP_SET_DEV: begin
          if (args_ok && (i_cmd.node != ed_adp_r)) begin
            ed_nxt[i_cmd.node].en = 1'b1;
            ed_nxt[i_cmd.node].control_status_address = i_cmd.control_status_address;
            ed_nxt[i_cmd.node].model = i_cmd.model;
          end else begin
            err_nxt = 1'b1;
          end
        end
        sat_pkg::SAT_OP_CLEAR: begin
          ed_nxt[i_cmd.node].en = 1'b0;
        end
        sat_pkg::SAT_OP_EXIT: begin
          nv_nxt = ed_r;
          nv_adp_nxt = ed_adp_r;
        end
        sat_pkg::SAT_OP_QUIT: begin
          ed_nxt = nv_r;
          ed_adp_nxt = nv_adp_r;
        end
        default: begin
          err_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    nv_r <= nv_nxt;
    nv_adp_r <= nv_adp_nxt;
    if (i_rst) begin
      for (int i = 0; i < NODES; i++) begin
        ed_r[i] <= '0;
      end
      ed_adp_r <= `SAT_BLANK_ADP_NODE;
      ack_r <= 1'b0;
      err_r <= 1'b0;
      show_r <= '0;
    end else begin
      ed_r <= ed_nxt;
      ed_adp_r <= ed_adp_nxt;
      ack_r <= ack_nxt;
      err_r <= err_nxt;
      show_r <= show_nxt;
    end
  end

  // Per-node compare against stored, enabled entries only
  logic [NODES-1:0] hit_base;
  logic [NODES-1:0] hit_hi;
  for (genvar g = 0; g < NODES; g++) begin : g_dec
    logic live;
    assign live = nv_r[g].en && (3'(g) != nv_adp_r);
    assign hit_base[g] = live && (i_bus_addr == nv_r[g].control_status_address);
    assign hit_hi[g] = live
                     && (i_bus_addr == nv_r[g].control_status_address + `SAT_CSR_SPAN);
  end

  // Decode result; silent in maintenance so only the service address answers
  logic hit_r;
  logic hit_nxt;
  logic [2:0] node_r;
  logic [2:0] node_nxt;
  logic reg_r;
  logic reg_nxt;

  always_comb begin
    hit_nxt = 1'b0;
    node_nxt = 3'h0;
    reg_nxt = 1'b0;
    if (i_bus_valid && !maint) begin
      for (int i = NODES - 1; i >= 0; i--) begin
        if (hit_base[i] || hit_hi[i]) begin
          hit_nxt = 1'b1;
          node_nxt = 3'(i);
          reg_nxt = hit_hi[i];
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      hit_r <= 1'b0;
      node_r <= 3'h0;
      reg_r <= 1'b0;
    end else begin
      hit_r <= hit_nxt;
      node_r <= node_nxt;
      reg_r <= reg_nxt;
    end
  end

  assign o_cmd_ack = ack_r;
  assign o_cmd_err = err_r;
  assign o_show = show_r;
  assign o_bus_hit = hit_r;
  assign o_bus_node = node_r;
  assign o_bus_reg = reg_r;
  assign o_in_maint = maint_d_r;
  assign o_adp_node = ed_adp_r;
endmodule // sat_table

//--- dv/sat_table_properties.sv
// Port checker for the storage adapter address table
module sat_table_properties (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_cmd_valid,
  input wire logic [17:0] i_cmd_addr,
  input wire sat_pkg::sat_cmd_t i_cmd,
  input wire logic i_bus_valid,
  input wire logic o_cmd_ack,
  input wire logic o_cmd_err,
  input wire sat_pkg::sat_show_t o_show,
  input wire logic o_bus_hit,
  input wire logic [2:0] o_bus_node,
  input wire logic o_in_maint,
  input wire logic [2:0] o_adp_node
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Commands answered only in maintenance, at one of the four maintenance addresses
  property p_ack_cause;
    o_cmd_ack |-> $past(i_cmd_valid) && o_in_maint;
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("stray ack");
  property p_ack_addr;
    o_cmd_ack |-> $past(i_cmd_addr[17:4]) == 14'h3F91
      && $past(i_cmd_addr[1:0]) == 2'h0;
  endproperty
  a_ack_addr: assert property (p_ack_addr)
    else $error("ack off address");
  property p_err_op;
    o_cmd_err |-> o_cmd_ack
      && $past(i_cmd.op) == sat_pkg::SAT_OP_SET_DEV;
  endproperty
  a_err_op: assert property (p_err_op)
    else $error("err without set");
  // Decode only outside maintenance, never for the adapter itself
  property p_hit_cause;
    o_bus_hit |-> $past(i_bus_valid) && !o_in_maint;
  endproperty
  a_hit_cause: assert property (p_hit_cause)
    else $error("stray hit");
  property p_no_node;
    !o_bus_hit |-> o_bus_node == 3'h0;
  endproperty
  a_no_node: assert property (p_no_node)
    else $error("node without hit");
  property p_not_adp;
    o_bus_hit |-> o_bus_node != o_adp_node;
  endproperty
  a_not_adp: assert property (p_not_adp)
    else $error("adapter decoded");
  property p_show_ack;
    $changed(o_show) |-> o_cmd_ack;
  endproperty
  a_show_ack: assert property (p_show_ack)
    else $error("show moved");
  property p_adp_hold;
    !o_in_maint |-> $stable(o_adp_node);
  endproperty
  a_adp_hold: assert property (p_adp_hold)
    else $error("adapter moved");
endmodule // sat_table_properties

bind sat_table sat_table_properties u_props (.i_sys_clk, .i_rst, .i_cmd_valid,
  .i_cmd_addr, .i_cmd, .i_bus_valid, .o_cmd_ack, .o_cmd_err, .o_show,
  .o_bus_hit, .o_bus_node, .o_in_maint, .o_adp_node);

//--- dv/sat_host_model.sv
// Host processor model issuing maintenance commands and bus cycles
module sat_host_model (
  input wire logic i_sys_clk,
  input wire logic i_ack,
  input wire logic i_err,
  output logic o_cmd_valid,
  output logic [17:0] o_cmd_addr,
  output sat_pkg::sat_cmd_t o_cmd, // No vector field; host assigns them
  output logic o_bus_valid,
  output logic [17:0] o_bus_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_addr = 18'h00000;
    o_cmd = '0;
    o_bus_valid = 1'b0;
    o_bus_addr = 18'h00000;
  end
  // One strobe per command; released address inverted, not left stale
  task automatic issue(input logic [17:0] a, input sat_pkg::sat_cmd_t c,
                       output logic [1:0] r);
    @(posedge i_sys_clk);
    #1 o_cmd_valid = 1'b1;
    o_cmd_addr = a;
    o_cmd = c;
    @(posedge i_sys_clk);
    #1 o_cmd_valid = 1'b0;
    o_cmd_addr = ~a;
    r = {i_ack, i_err};
  endtask
  // Single bus address cycle, answer read by caller right after
  task automatic decode(input logic [17:0] a);
    @(posedge i_sys_clk);
    #1 o_bus_valid = 1'b1;
    o_bus_addr = a;
    @(posedge i_sys_clk);
    #1 o_bus_valid = 1'b0;
    o_bus_addr = ~a;
  endtask
endmodule // sat_host_model

//--- dv/sat_table_bench.sv
// Self-checking bench for the storage adapter address table
module sat_table_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic maint = 1'b0;
  logic erase = 1'b1;
  logic [1:0] sel = 2'h0;
  logic cv, bv, ack, err, hit, rw, in_m;
  logic [17:0] ca, ba;
  logic [2:0] bnode, adp;
  logic [1:0] r;
  sat_pkg::sat_cmd_t cmd;
  sat_pkg::sat_show_t show;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #50 clk = ~clk;
  sat_table dut (.i_sys_clk(clk), .i_rst(rst), .i_maint_sw(maint),
    .i_ctrl_sel_sw(sel), .i_nv_erase(erase), .i_cmd_valid(cv),
    .i_cmd_addr(ca), .i_cmd(cmd), .i_bus_valid(bv), .i_bus_addr(ba),
    .o_cmd_ack(ack), .o_cmd_err(err), .o_show(show), .o_bus_hit(hit),
    .o_bus_node(bnode), .o_bus_reg(rw), .o_in_maint(in_m),
    .o_adp_node(adp));
  sat_host_model host (.i_sys_clk(clk), .i_ack(ack), .i_err(err),
    .o_cmd_valid(cv), .o_cmd_addr(ca), .o_cmd(cmd), .o_bus_valid(bv),
    .o_bus_addr(ba));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %0h vs %0h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Command at the address picked by the selector switches
  task automatic cm(input sat_pkg::sat_op_t op, input logic [2:0] n,
                    input logic [17:0] c, input logic [7:0] m);
    host.issue(18'h3F910 + {14'h0000, sel, 2'h0}, '{op, n, c, m}, r);
  endtask
  task automatic dc(input logic [17:0] a, input logic [4:0] e);
    host.decode(a);
    chk({hit, bnode, rw}, e);
  endtask
  // Switch change needs the synchroniser plus one flop
  task automatic mode(input logic m);
    @(posedge clk);
    #1 maint = m;
    for (int i = 0; i < 8 && in_m !== m; i++) begin
      @(posedge clk);
      #1;
    end
    chk(in_m, m);
  endtask
  task automatic t_blank_and_set;
    cm(sat_pkg::SAT_OP_SHOW, 3'h7, 18'h0, 8'h0);
    chk({r, show.node, show.is_adp, adp}, 9'h17F);
    cm(sat_pkg::SAT_OP_SET_DEV, 3'h0, 18'h3F468, 8'h15);
    chk(r, 2'h2);
    cm(sat_pkg::SAT_OP_SET_DEV, 3'h1, 18'h3E0DC, 8'h16);
    cm(sat_pkg::SAT_OP_SHOW, 3'h0, 18'h0, 8'h0);
    chk(show, {3'h0, 1'b0, 1'b1, 18'h3F468, 8'h15});
  endtask
  task automatic t_refuse;
    cm(sat_pkg::SAT_OP_SET_DEV, 3'h2, 18'h3F468, 8'h17);
    chk(r, 2'h3);
    cm(sat_pkg::SAT_OP_SET_DEV, 3'h7, 18'h3F468, 8'h15);
    chk(r, 2'h3);
    host.issue(18'h3F920, '0, r);
    chk(r, 2'h0);
    for (int s = 3; s >= 0; s--) begin
      sel = 2'(s);
      repeat (4) @(posedge clk);
      cm(sat_pkg::SAT_OP_SHOW, 3'h1, 18'h0, 8'h0);
      chk({r, show.entry}, {2'h2, 1'b1, 18'h3E0DC, 8'h16});
    end
    dc(18'h3F468, 5'h00);
  endtask
  task automatic t_commit_quit;
    cm(sat_pkg::SAT_OP_EXIT, 3'h0, 18'h0, 8'h0);
    mode(1'b0);
    dc(18'h3F468, 5'h10);
    dc(18'h3F46A, 5'h11);
    dc(18'h3E0DC, 5'h12);
    dc(18'h3F46C, 5'h00);
    mode(1'b1);
    cm(sat_pkg::SAT_OP_CLEAR, 3'h0, 18'h0, 8'h0);
    cm(sat_pkg::SAT_OP_QUIT, 3'h0, 18'h0, 8'h0);
    cm(sat_pkg::SAT_OP_SHOW, 3'h0, 18'h0, 8'h0);
    chk({r, show.entry.en}, 3'h5);
    mode(1'b0);
    dc(18'h3F468, 5'h10);
    mode(1'b1);
    cm(sat_pkg::SAT_OP_CLEAR, 3'h0, 18'h0, 8'h0);
    cm(sat_pkg::SAT_OP_SET_ADP, 3'h3, 18'h0, 8'h0);
    cm(sat_pkg::SAT_OP_EXIT, 3'h0, 18'h0, 8'h0);
    mode(1'b0);
    dc(18'h3F468, 5'h00);
    chk(adp, 3'h3);
  endtask
  // Stored table must survive a reset; only the working copy clears
  task automatic t_keep_over_reset;
    @(posedge clk);
    #1 rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    dc(18'h3E0DC, 5'h12);
  endtask
  // Hang guard, well above the hundred or so cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    erase = 1'b0;
    mode(1'b1);
    t_blank_and_set();
    t_refuse();
    t_commit_quit();
    t_keep_over_reset();
    end_of_test();
  end
endmodule // sat_table_bench
